// >>> rtl/csm_pkg.sv
package csm_pkg;
  // ************************************************************
  // Frame and field layout
  // ************************************************************
  localparam int CSM_WORD_W = 16;
  localparam int CSM_NUM_IN = 8;
  localparam logic [4:0] CSM_BIT_CNT_RST = 5'h00;
  localparam logic [4:0] CSM_BIT_CNT_FULL = 5'h10;
  // Command word fields
  localparam int CSM_CMD_MASK_LSB = 0;
  localparam int CSM_CMD_POL_LO = 8;
  localparam int CSM_CMD_POL_HI = 9;
  localparam int CSM_CMD_DOD = 10;
  localparam int CSM_CMD_WEN = 11;
  localparam int CSM_CMD_HYST_EN = 12;
  localparam int CSM_CMD_SCAN_LSB = 13;
  // Status word fields
  localparam int CSM_STS_SW_LSB = 0;
  localparam int CSM_STS_TEMP = 8;
  // Reset values: all inputs enabled, direct mode on inputs 0/1, ground type
  localparam logic [15:0] CSM_CMD_RST = 16'h0000;
  localparam logic [7:0] CSM_SW_RST = 8'h00;
  localparam logic [2:0] CSM_SCAN_PER_RST = 3'h0;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CSM_CLK_MHZ = 200;
  localparam int CSM_DEB_US = 5000;
  localparam int CSM_DEB_CYC = CSM_DEB_US * CSM_CLK_MHZ;
  localparam int CSM_SCAN_PULSE_US = 250;
  localparam int CSM_SCAN_PULSE_CYC = CSM_SCAN_PULSE_US * CSM_CLK_MHZ;
  localparam int CSM_SCAN_BASE_US = 1000;
  localparam int CSM_SCAN_BASE_CYC = CSM_SCAN_BASE_US * CSM_CLK_MHZ;
  typedef enum logic [1:0] {CSM_NORMAL, CSM_SCAN, CSM_SHUTDOWN} csm_mode_t;
endpackage

// >>> rtl/csm_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of pins
module csm_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  // First stage only feeds the second
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// >>> rtl/csm_top.sv
`timescale 1ns/1ps
// Operation
// - Command word is latched only when chip select rises after a frame of at least sixteen clocks
// - SDO shifts next bit on each serial clock rising edge after the first while selected
// - SDO output enable is off whenever chip select is high
// - SDI sampled on serial clock falling edges while selected
// - Interrupt pulled low on debounced change of an enabled input
// - Overtemp output pulled low when thermal warning is present
// - Direct outputs follow inputs 0/1 only with direct mode and normal mode
// - Three modes: normal, scan and shutdown; monitoring in normal and during scan pulses
// - Scan mode connects sense resistors only for a short pulse per period
// - Shutdown leaves all inputs unconnected, no sense resistors
// - Each input has its own status bit in the status word
// - Per-input interrupt mask bits written through the command word
// - After reset every input is enabled for interrupts
// - Inputs 0-3 ground type; 4-7 pairwise selectable ground or battery
// - Reset: inputs 2-7 ground type, inputs 0/1 direct inputs
// - Ground type pulled up, battery type pulled down
// - Direct mode disconnects sense on inputs 0/1; the shared wetting enable is unaffected
// - Direct inputs never update status nor raise interrupts
// - One shared debounce, hysteresis and wetting setting for all inputs
// - Serial port reads status and writes masks, enables, polarity, period
// - Interrupt released when chip select falls
// - Mask bit clear enables the input, set masks it
// - Both words are sixteen bits, most significant bit first
// - Status and interrupt change only after the new state holds stable
module csm_top
  import csm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_clk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic [7:0] switch_input,
  input wire logic shutdown_n,
  input wire logic thermal_warn,
  output logic change_irq_n_o,
  output logic change_irq_n_oe,
  output logic overtemp_warn_n_o,
  output logic overtemp_warn_n_oe,
  output logic direct_level_out_0,
  output logic direct_level_out_1,
  output logic direct_out_oe,
  output logic [7:0] sense_enable,
  output logic [7:0] pull_up_sel,
  output logic wetting_enable,
  output logic hyst_enable
);
  // ************************************************************
  // Input synchronisation
  // ************************************************************
  logic [11:0] sync_q;
  // Idle-high pins enter inverted, so the all-zero synchroniser reset
  // reads as deselected and running and no false edge follows reset
  wire [11:0] pin_raw = {~shutdown_n, spi_sdi, spi_clk, ~spi_cs_n, switch_input};
  csm_sync #(.W(12)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d(pin_raw),
    .q(sync_q)
  );
  wire [7:0] in_s = sync_q[7:0];
  wire cs_s = !sync_q[8];
  wire sck_s = sync_q[9];
  wire sdi_s = sync_q[10];
  wire shdn_n_s = !sync_q[11];
  logic temp_s;
  logic temp_meta;
  // Thermal flag has its own pair of flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      temp_meta <= 1'b0;
      temp_s <= 1'b0;
    end else begin
      temp_meta <= thermal_warn;
      temp_s <= temp_meta;
    end
  end

  // ************************************************************
  // Serial port
  // ************************************************************
  logic cs_d;
  logic sck_d;
  logic [15:0] shift_in;
  logic [15:0] shift_out;
  logic [15:0] cmd;
  logic [4:0] bit_cnt;
  logic [7:0] sw_state;
  wire cs_fall = cs_d && !cs_s;
  wire cs_rise = !cs_d && cs_s;
  wire sck_rise = !cs_s && sck_s && !sck_d;
  wire sck_fall = !cs_s && !sck_s && sck_d;
  wire [15:0] status_word = {7'h00, temp_s, sw_state};
  // Edge history of chip select and serial clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cs_d <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      cs_d <= cs_s;
      sck_d <= sck_s;
    end
  end
  // Shift in on falling edge, MSB first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shift_in <= 16'h0000;
      bit_cnt <= CSM_BIT_CNT_RST;
    end else if (cs_fall) begin
      bit_cnt <= CSM_BIT_CNT_RST;
    end else if (sck_fall) begin
      shift_in <= {shift_in[14:0], sdi_s};
      if (bit_cnt != CSM_BIT_CNT_FULL) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end
  // Status loaded at frame start; next bit on each rising edge after the first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shift_out <= 16'h0000;
    end else if (cs_fall) begin
      shift_out <= status_word;
    end else if (sck_rise && bit_cnt != 5'h00) begin
      shift_out <= {shift_out[14:0], 1'b0};
    end
  end
  // Command takes effect on chip select rising, full words only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd <= CSM_CMD_RST;
    end else if (cs_rise && bit_cnt == CSM_BIT_CNT_FULL) begin
      cmd <= shift_in;
    end
  end
  // SDO from flops; released while deselected
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      spi_sdo <= shift_out[15];
      spi_sdo_oe <= !cs_s;
    end
  end

  // ************************************************************
  // Command decode
  // ************************************************************
  wire [7:0] mask = cmd[CSM_CMD_MASK_LSB +: 8];
  wire pol_lo = cmd[CSM_CMD_POL_LO];
  wire pol_hi = cmd[CSM_CMD_POL_HI];
  wire direct_dis = cmd[CSM_CMD_DOD];
  wire [2:0] scan_per = cmd[CSM_CMD_SCAN_LSB +: 3];
  // Battery type inputs pull down, all others pull up
  wire [7:0] batt_type = {pol_hi, pol_hi, pol_lo, pol_lo, 4'h0};
  wire direct_mode = !direct_dis;
  wire [7:0] direct_msk = {6'h00, direct_mode, direct_mode};

  // ************************************************************
  // Mode control
  // ************************************************************
  csm_mode_t mode;
  csm_mode_t next_mode;
  logic [31:0] scan_cnt;
  logic scan_pulse;
  logic deb_busy;
  wire [31:0] scan_len = CSM_SCAN_BASE_CYC * (32'(scan_per) + 32'h1);
  // Shutdown pin wins; nonzero scan period selects scan mode unless a debounce is running
  always_comb begin
    case (mode)
      CSM_SHUTDOWN: next_mode = shdn_n_s ? CSM_NORMAL : CSM_SHUTDOWN;
      CSM_NORMAL: next_mode = (scan_per != CSM_SCAN_PER_RST && !deb_busy) ?
                              CSM_SCAN : CSM_NORMAL;
      CSM_SCAN: next_mode = (scan_per == CSM_SCAN_PER_RST || deb_busy) ?
                            CSM_NORMAL : CSM_SCAN;
      default: next_mode = CSM_NORMAL;
    endcase
    if (!shdn_n_s) begin
      next_mode = CSM_SHUTDOWN;
    end
  end
  // Mode register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode <= CSM_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end
  // Scan period timer; sensing only during the pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n || mode != CSM_SCAN) begin
      scan_cnt <= 32'h0;
      scan_pulse <= 1'b1;
    end else begin
      scan_cnt <= (scan_cnt >= scan_len - 32'h1) ? 32'h0 : scan_cnt + 32'h1;
      scan_pulse <= scan_cnt < 32'(CSM_SCAN_PULSE_CYC);
    end
  end
  wire sensing = (mode == CSM_NORMAL) || (mode == CSM_SCAN && scan_pulse);

  // ************************************************************
  // Shared debounce, status and interrupt
  // ************************************************************
  logic [31:0] deb_cnt;
  logic [7:0] cand;
  logic irq;
  wire [7:0] monitored = ~direct_msk;
  wire [7:0] diff = (in_s ^ sw_state) & monitored;
  wire [7:0] irq_hit = diff & ~mask;
  // Direct inputs may toggle fast; they must not restart the shared timer
  wire cand_moved = ((in_s ^ cand) & monitored) != 8'h00;
  // One timer for all inputs; restarts whenever the candidate changes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      deb_cnt <= 32'h0;
      cand <= CSM_SW_RST;
      deb_busy <= 1'b0;
    end else if (!sensing || diff == 8'h00) begin
      deb_cnt <= 32'h0;
      deb_busy <= 1'b0;
      cand <= in_s;
    end else if (cand_moved) begin
      deb_cnt <= 32'h0;
      cand <= in_s;
      deb_busy <= 1'b1;
    end else if (deb_cnt < 32'(CSM_DEB_CYC)) begin
      deb_cnt <= deb_cnt + 32'h1;
      deb_busy <= 1'b1;
    end
  end
  wire deb_done = deb_busy && deb_cnt == 32'(CSM_DEB_CYC) && !cand_moved;
  // Status update after stable debounce time
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sw_state <= CSM_SW_RST;
    end else if (deb_done) begin
      sw_state <= (sw_state & ~monitored) | (in_s & monitored);
    end
  end
  // Change set wins over clear by chip select fall
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (deb_done && irq_hit != 8'h00) begin
      irq <= 1'b1;
    end else if (cs_fall) begin
      irq <= 1'b0;
    end
  end
  logic temp_latch;
  // Overtemp warning held until a frame starts
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      temp_latch <= 1'b0;
    end else if (temp_s && !temp_latch && !cs_fall) begin
      temp_latch <= 1'b1;
    end else if (cs_fall) begin
      temp_latch <= 1'b0;
    end
  end

  // ************************************************************
  // Pin outputs
  // ************************************************************
  // Every pin from a flop, so no decode glitch reaches the board
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      change_irq_n_o <= 1'b0;
      change_irq_n_oe <= 1'b0;
      overtemp_warn_n_o <= 1'b0;
      overtemp_warn_n_oe <= 1'b0;
      direct_level_out_0 <= 1'b0;
      direct_level_out_1 <= 1'b0;
      direct_out_oe <= 1'b0;
      sense_enable <= 8'h00;
      pull_up_sel <= 8'hFF;
      wetting_enable <= 1'b0;
      hyst_enable <= 1'b0;
    end else begin
      change_irq_n_oe <= irq;
      overtemp_warn_n_oe <= temp_latch;
      direct_level_out_0 <= in_s[0];
      direct_level_out_1 <= in_s[1];
      direct_out_oe <= direct_mode && mode == CSM_NORMAL;
      sense_enable <= sensing ? monitored : 8'h00;
      pull_up_sel <= ~batt_type;
      wetting_enable <= cmd[CSM_CMD_WEN] && sensing && !temp_s;
      hyst_enable <= !cmd[CSM_CMD_HYST_EN] && mode == CSM_NORMAL;
    end
  end
endmodule

// >>> verif/csm_top_sva.sv
`timescale 1ns/1ps
// ************************************************************
// Port-level checks of the switch monitor
// ************************************************************
module csm_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_clk,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  input wire logic [7:0] switch_input,
  input wire logic shutdown_n,
  input wire logic thermal_warn,
  input wire logic change_irq_n_o,
  input wire logic change_irq_n_oe,
  input wire logic overtemp_warn_n_o,
  input wire logic overtemp_warn_n_oe,
  input wire logic direct_level_out_0,
  input wire logic direct_level_out_1,
  input wire logic direct_out_oe,
  input wire logic [7:0] sense_enable
);
  // One domain, so clock and reset are stated once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Windows allow for the pin synchronisers, about three cycles
  chk_sdo_released: assert property (spi_cs_n [*6] |-> !spi_sdo_oe)
    else $error("sdo driven while deselected");
  chk_sdo_drive: assert property ($fell(spi_cs_n) |-> ##[1:6] spi_sdo_oe)
    else $error("sdo not driven after select");
  chk_sdo_hold: assert property ((!spi_cs_n && !spi_clk) [*8] |-> $stable(spi_sdo))
    else $error("sdo moved without a clock rise");
  chk_irq_clear: assert property ($fell(spi_cs_n) |-> ##[1:6] !change_irq_n_oe)
    else $error("interrupt not released on select");
  chk_temp_clear: assert property ($fell(spi_cs_n) |-> ##[1:6] !overtemp_warn_n_oe)
    else $error("overtemp not released on select");
  chk_temp_raise: assert property ($rose(thermal_warn) && spi_cs_n
    |-> ##[1:8] overtemp_warn_n_oe)
    else $error("overtemp not pulled low");
  chk_pins_low: assert property (!change_irq_n_o && !overtemp_warn_n_o)
    else $error("open-drain pin driven high");
  chk_shutdown_off: assert property (!shutdown_n [*8]
    |-> sense_enable == 8'h00 && !direct_out_oe)
    else $error("inputs active in shutdown");
  chk_direct_follow: assert property ((direct_out_oe && $stable(switch_input[1:0])) [*6]
    |-> direct_level_out_0 == switch_input[0] && direct_level_out_1 == switch_input[1])
    else $error("direct output not following input");
  chk_direct_sense: assert property (direct_out_oe [*3] |-> sense_enable[1:0] == 2'b00)
    else $error("sense on while direct");
endmodule
bind csm_top csm_sva u_sva (.sys_clk, .rst_n, .spi_cs_n, .spi_clk, .spi_sdo, .spi_sdo_oe,
  .switch_input, .shutdown_n, .thermal_warn, .change_irq_n_o, .change_irq_n_oe,
  .overtemp_warn_n_o, .overtemp_warn_n_oe, .direct_level_out_0, .direct_level_out_1,
  .direct_out_oe, .sense_enable);

// >>> verif/csm_spi_master.sv
`timescale 1ns/1ps
// ************************************************************
// Serial master standing in for the microcontroller
// ************************************************************
module csm_spi_master (
  output logic spi_cs_n,
  output logic spi_clk,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe
);
  // Idle: deselected, clock low, data at its pull-down level
  initial begin
    spi_cs_n = 1'b1;
    spi_clk = 1'b0;
    spi_sdi = 1'b0;
  end
  // One frame of nbits; data changes 20 ns after a fall to give hold time.
  // SDO is taken at each fall: the bit launched by the rise has settled by then
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    spi_cs_n = 1'b0;
    #60;
    for (int i = 0; i < nbits; i++) begin
      #20;
      spi_sdi = tx[15 - i];
      #4;
      spi_clk = 1'b1;
      #24;
      rx[15 - i] = spi_sdo_oe ? spi_sdo : 1'bx;
      spi_clk = 1'b0;
    end
    #52;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
    #60;
  endtask
endmodule

// >>> verif/csm_top_tb.sv
`timescale 1ns/1ps
// ************************************************************
// Testbench
// ************************************************************
module csm_top_tb;
  import csm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] switch_input = 8'h00;
  logic shutdown_n = 1'b1;
  logic thermal_warn = 1'b0;
  logic spi_cs_n, spi_clk, spi_sdi, spi_sdo, spi_sdo_oe;
  logic direct_level_out_0, direct_level_out_1, direct_out_oe, change_irq_n_oe, overtemp_warn_n_oe;
  logic [7:0] sense_enable, pull_up_sel;
  logic wetting_enable, hyst_enable;
  logic [15:0] rx;
  int errors = 0;
  int compares = 0;
  always #2.5 sys_clk = ~sys_clk;
  csm_top dut (.sys_clk, .rst_n, .spi_cs_n, .spi_clk, .spi_sdi, .spi_sdo, .spi_sdo_oe,
    .switch_input, .shutdown_n, .thermal_warn, .change_irq_n_o(), .change_irq_n_oe,
    .overtemp_warn_n_o(), .overtemp_warn_n_oe, .direct_level_out_0, .direct_level_out_1,
    .direct_out_oe, .sense_enable, .pull_up_sel, .wetting_enable, .hyst_enable);
  csm_spi_master u_master (.spi_cs_n, .spi_clk, .spi_sdi, .spi_sdo, .spi_sdo_oe);
  // Compare and count; an unknown never matches
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic give_verdict;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Debounce is a million cycles, so the tests stay on paths that do not wait for it
  initial begin
    idle(8);
    rst_n = 1'b1;
    idle(10);
    check(16'(pull_up_sel), 16'h00FF);
    check(16'({direct_out_oe, sense_enable[1:0]}), 16'h0004);
    check(16'({spi_sdo_oe, change_irq_n_oe, overtemp_warn_n_oe}), 16'h0000);
    check(16'({wetting_enable, hyst_enable}), 16'h0001);
    u_master.xfer(16'h0000, 16, rx);
    check(rx, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      switch_input[1:0] = 2'(i);
      idle(8);
      check(16'({direct_level_out_1, direct_level_out_0}), 16'(i));
    end
    $display("test direct done");
    thermal_warn = 1'b1;
    idle(8);
    check(16'(overtemp_warn_n_oe), 16'h0001);
    u_master.xfer(16'h0F00, 16, rx);
    check(rx, 16'h0100);
    idle(6);
    check(16'(pull_up_sel), 16'h000F);
    check(16'({direct_out_oe, sense_enable}), 16'h00FF);
    check(16'({wetting_enable, hyst_enable}), 16'h0001);
    thermal_warn = 1'b0;
    idle(6);
    check(16'({wetting_enable, hyst_enable}), 16'h0003);
    $display("test config done");
    u_master.xfer(16'h0000, 8, rx);
    idle(6);
    check(16'(pull_up_sel), 16'h000F);
    $display("test short frame done");
    u_master.xfer(16'h2000, 16, rx);
    check(rx, 16'h0000);
    idle(8);
    check(16'({hyst_enable, direct_out_oe, sense_enable}), 16'h00FC);
    $display("test scan done");
    shutdown_n = 1'b0;
    idle(10);
    check(16'({direct_out_oe, sense_enable}), 16'h0000);
    shutdown_n = 1'b1;
    u_master.xfer(16'h0000, 16, rx);
    idle(8);
    check(16'({direct_out_oe, pull_up_sel}), 16'h01FF);
    $display("test shutdown done");
    give_verdict();
  end
  // Hang guard
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
endmodule
